//--- ssp_pkg.sv
// Purpose: shared constants for the switch configured serial port
// Assumes: 25 MHz system clock, 16x oversampled bit timing
// Notes:   baud figures are held in tenths so 134.5 stays exact
package ssp_pkg;
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned OVERSAMPLE = 16;
  // accumulator wraps at ten times the clock rate (rates are in tenths)
  localparam logic [27:0] BAUD_ACC_LIMIT = 28'(CLK_HZ * 10);
  localparam logic [3:0]  PHASE_LAST     = 4'(OVERSAMPLE - 1);
  localparam logic [3:0]  PHASE_MID      = 4'(OVERSAMPLE / 2 - 1);

  // ---------------------------------------------------------------------
  // register map (byte addresses) and fields
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_DATA     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0C;
  localparam logic [7:0] OFS_CONFIG   = 8'h10;
  localparam int ST_RX_READY  = 0;
  localparam int ST_OVERRUN   = 1;
  localparam int ST_TX_EMPTY  = 2;
  localparam int ST_FRAME_ERR = 3;
  localparam int ST_PAR_ERR   = 4;
  localparam int ST_W         = 5;
  localparam logic [4:0] INT_MASK_RST = 5'h00;
  localparam logic [7:0] RX_DATA_RST  = 8'h00;

  // receiver states
  typedef enum logic [1:0] {
    SSP_RX_IDLE  = 2'b00,
    SSP_RX_START = 2'b01,
    SSP_RX_BITS  = 2'b10,
    SSP_RX_STOP  = 2'b11
  } ssp_rx_state_t;

  // baud rate in tenths of a baud for each switch code
  function automatic logic [16:0] ssp_baud_x10(input logic [3:0] code);
    case (code)
      4'h1:    ssp_baud_x10 = 17'd1500;
      4'h2:    ssp_baud_x10 = 17'd3000;
      4'h3:    ssp_baud_x10 = 17'd24000;
      4'h4:    ssp_baud_x10 = 17'd12000;
      4'h5:    ssp_baud_x10 = 17'd18000;
      4'h6:    ssp_baud_x10 = 17'd48000;
      4'h7:    ssp_baud_x10 = 17'd96000;
      4'h8:    ssp_baud_x10 = 17'd24000;
      4'h9:    ssp_baud_x10 = 17'd6000;
      4'hA:    ssp_baud_x10 = 17'd2000;
      4'hB:    ssp_baud_x10 = 17'd1345;
      4'hC:    ssp_baud_x10 = 17'd750;
      4'hD:    ssp_baud_x10 = 17'd500;
      default: ssp_baud_x10 = 17'd1100; // codes 0, 14 and 15
    endcase
  endfunction : ssp_baud_x10

  // mask keeping the low data bits for a length code (0 = 5 bits)
  function automatic logic [7:0] ssp_len_mask(input logic [1:0] len);
    ssp_len_mask = 8'hFF >> (2'h3 - len);
  endfunction : ssp_len_mask
endpackage : ssp_pkg

//--- ssp_tx.sv
// Purpose: serial character transmitter
// Assumes: tick_in is a one-cycle 16x bit-rate pulse
// Notes:   format is latched at start so switch changes wait a frame
`timescale 1ns/1ps
`default_nettype none
module ssp_tx import ssp_pkg::*; (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // character and format
  input  wire logic       tick_in,
  input  wire logic       start_in,
  input  wire logic [7:0] data_in,
  input  wire logic [1:0] len_in,
  input  wire logic       par_en_in,
  input  wire logic       par_odd_in,
  input  wire logic       two_stop_in,
  // line
  output logic            txd_out,
  output logic            busy_out
);
  logic [11:0] shreg;
  logic [3:0]  bits_left;
  logic [3:0]  phase;
  logic [7:0]  dmask;
  logic [11:0] next_frame;
  logic [3:0]  next_bits;

  // frame: start, data lsb first, parity, then stop bits (ones)
  always_comb begin
    dmask      = data_in & ssp_len_mask(len_in);
    // shift held at four bits so an eight-bit length does not wrap to zero
    next_frame = {3'h7, dmask, 1'b0}
                 | (12'hFFE << (4'd5 + {2'h0, len_in}));
    if (par_en_in) begin
      next_frame[6 + len_in] = (^dmask) ^ par_odd_in;
    end
    // count covers start, data, parity and every stop bit
    next_bits = 4'd7 + {2'h0, len_in} + {3'h0, par_en_in}
                + {3'h0, two_stop_in};
  end

  // shift engine; line rests at mark between characters
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      shreg     <= 12'hFFF;
      bits_left <= 4'h0;
      phase     <= 4'h0;
      busy_out  <= 1'b0;
      txd_out   <= 1'b1;
    end else if (!busy_out && start_in) begin
      shreg     <= next_frame;
      bits_left <= next_bits;
      phase     <= 4'h0;
      busy_out  <= 1'b1;
      txd_out   <= 1'b0;
    end else if (busy_out && tick_in) begin
      if (phase == PHASE_LAST) begin
        phase <= 4'h0;
        if (bits_left == 4'h1) begin
          busy_out <= 1'b0;
          txd_out  <= 1'b1;
        end else begin
          shreg     <= {1'b1, shreg[11:1]};
          txd_out   <= shreg[1];
          bits_left <= bits_left - 4'h1;
        end
      end else begin
        phase <= phase + 4'h1;
      end
    end
  end

  sequence s_tx_go;
    start_in && !busy_out;
  endsequence
  AST_TX_START_BIT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_tx_go |=> (!txd_out && busy_out) [*8])
    else $error("start bit not driven low");
  AST_TX_IDLE_MARK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !busy_out |-> txd_out)
    else $error("line not at mark while idle");
endmodule : ssp_tx
`default_nettype wire

//--- ssp_rx.sv
// Purpose: serial character receiver
// Assumes: rxd_in already synchronised to clk_in
// Notes:   only the first stop bit is checked
`timescale 1ns/1ps
`default_nettype none
module ssp_rx import ssp_pkg::*; (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // line and format
  input  wire logic       tick_in,
  input  wire logic       rxd_in,
  input  wire logic [1:0] len_in,
  input  wire logic       par_en_in,
  input  wire logic       par_odd_in,
  // character out
  output logic            done_out,
  output logic [7:0]      data_out,
  output logic            frame_err_out,
  output logic            par_err_out
);
  ssp_rx_state_t state;
  logic [8:0]    shreg;
  logic [3:0]    phase;
  logic [3:0]    cnt;
  logic [3:0]    nbits;
  logic [8:0]    word;

  always_comb begin
    nbits = 4'd5 + {2'h0, len_in} + {3'h0, par_en_in};
    word  = shreg >> (4'd9 - nbits);
  end

  // start found mid-bit, then one sample per bit centre
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state         <= SSP_RX_IDLE;
      shreg         <= 9'h000;
      phase         <= 4'h0;
      cnt           <= 4'h0;
      done_out      <= 1'b0;
      data_out      <= 8'h00;
      frame_err_out <= 1'b0;
      par_err_out   <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state)
        SSP_RX_IDLE: begin
          phase <= 4'h0;
          if (!rxd_in) state <= SSP_RX_START;
        end
        SSP_RX_START: if (tick_in) begin
          phase <= phase + 4'h1;
          if (phase == PHASE_MID) begin
            phase <= 4'h0;
            cnt   <= 4'h0;
            state <= rxd_in ? SSP_RX_IDLE : SSP_RX_BITS;
          end
        end
        SSP_RX_BITS: if (tick_in) begin
          phase <= phase + 4'h1;
          if (phase == PHASE_LAST) begin
            shreg <= {rxd_in, shreg[8:1]};
            cnt   <= cnt + 4'h1;
            if (cnt + 4'h1 == nbits) state <= SSP_RX_STOP;
          end
        end
        SSP_RX_STOP: if (tick_in) begin
          phase <= phase + 4'h1;
          if (phase == PHASE_LAST) begin
            state         <= SSP_RX_IDLE;
            done_out      <= 1'b1;
            data_out      <= word[7:0] & ssp_len_mask(len_in);
            frame_err_out <= !rxd_in;
            par_err_out   <= par_en_in &&
              ((^(word[7:0] & ssp_len_mask(len_in))) ^
               word[4'd5 + {2'h0, len_in}] ^ par_odd_in);
          end
        end
        default: state <= SSP_RX_IDLE;
      endcase
    end
  end

  AST_RX_FRAME: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state == SSP_RX_STOP && tick_in && phase == PHASE_LAST && !rxd_in)
    |=> done_out && frame_err_out)
    else $error("missing stop bit not flagged");
endmodule : ssp_rx
`default_nettype wire

//--- ssp_top.sv
// Purpose: switch configured async serial port with APB registers
// Assumes: switch and jumper pins are static; 1 = ON or fitted
// Notes:   zero-wait APB slave with a registered ready
`timescale 1ns/1ps
`default_nettype none
// How it works
// - four baud switches form code, first MSB
// - codes 8-13 include exact 134.5 baud
// - stop switch ON one, OFF two
// - parity sense used only when parity fitted
// - no jumpers means eight bits, no parity
// - two jumpers choose five to eight bits
// - third jumper adds and checks parity bit
// - start bit leads, stop bits trail
// - line held at mark while idle
// - parallel byte shifted out serially
// - status shows ready, overrun, empty, framing
// - data write strobe starts transmission
module ssp_top import ssp_pkg::*; (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // apb slave
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // serial line
  input  wire logic        rxd_in,
  output logic             txd_out,
  // switches and jumpers
  input  wire logic        stop_bit_count_switch_in,
  input  wire logic        baud_code_bit3_switch_in,
  input  wire logic        baud_code_bit2_switch_in,
  input  wire logic        baud_code_bit1_switch_in,
  input  wire logic        baud_code_bit0_switch_in,
  input  wire logic        parity_sense_switch_in,
  input  wire logic        char_len_jumper1_in,
  input  wire logic        char_len_jumper2_in,
  input  wire logic        parity_enable_jumper_in,
  // interrupt
  output logic             irq_out
);
  // ---------------------------------------------------------------------
  // pin synchronisers and configuration
  // ---------------------------------------------------------------------
  logic [9:0] pin_meta;
  logic [9:0] pin_sync;
  logic [3:0] baud_code;
  logic       two_stop;
  logic       par_en;
  logic       par_odd;
  logic [1:0] len;
  logic       rxd_s;

  // every pin passes two flops; meta stage is read by sync only
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_meta <= 10'h200;
      pin_sync <= 10'h200;
    end else begin
      pin_meta <= {rxd_in, stop_bit_count_switch_in,
                   baud_code_bit3_switch_in, baud_code_bit2_switch_in,
                   baud_code_bit1_switch_in, baud_code_bit0_switch_in,
                   parity_sense_switch_in, char_len_jumper1_in,
                   char_len_jumper2_in, parity_enable_jumper_in};
      pin_sync <= pin_meta;
    end
  end

  // decoded format; unfitted jumpers give 8 bits, no parity
  always_comb begin
    rxd_s     = pin_sync[9];
    two_stop  = !pin_sync[8];
    baud_code = pin_sync[7:4];
    par_en    = pin_sync[0];
    par_odd   = par_en && pin_sync[3];
    len       = {!pin_sync[1], !pin_sync[2]};
  end

  // ---------------------------------------------------------------------
  // fractional bit-rate generator
  // ---------------------------------------------------------------------
  logic [27:0] baud_acc;
  logic [27:0] baud_inc;
  logic [27:0] baud_sum;
  logic        tick;

  // rates in tenths keep 134.5 exact; jitter is one clock per tick
  always_comb begin
    baud_inc = {7'h00, ssp_baud_x10(baud_code), 4'h0};
    baud_sum = baud_acc + baud_inc;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      baud_acc <= 28'h0000000;
      tick     <= 1'b0;
    end else if (baud_sum >= BAUD_ACC_LIMIT) begin
      baud_acc <= baud_sum - BAUD_ACC_LIMIT;
      tick     <= 1'b1;
    end else begin
      baud_acc <= baud_sum;
      tick     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------
  logic       apb_setup;
  logic       apb_done;
  logic       wr_data;
  logic       rd_data;
  logic       rd_istat;
  logic       wr_mask;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  always_comb begin
    apb_setup = psel_in && !penable_in;
    apb_done  = psel_in && penable_in && pready_out;
    wr_data   = apb_done && pwrite_in && hit(paddr_in, OFS_DATA);
    rd_data   = apb_done && !pwrite_in && hit(paddr_in, OFS_DATA);
    rd_istat  = apb_done && !pwrite_in && hit(paddr_in, OFS_INT_STAT);
    wr_mask   = apb_done && pwrite_in && hit(paddr_in, OFS_INT_MASK);
  end

  // ---------------------------------------------------------------------
  // transmit holding register
  // ---------------------------------------------------------------------
  logic [7:0] hold_data;
  logic       hold_full;
  logic       tx_busy;
  logic       tx_start;

  assign tx_start = hold_full && !tx_busy;

  // a write while full is dropped; software polls the empty flag
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hold_data <= 8'h00;
      hold_full <= 1'b0;
    end else if (wr_data && !hold_full) begin
      hold_data <= pwdata_in[7:0];
      hold_full <= 1'b1;
    end else if (tx_start) begin
      hold_full <= 1'b0;
    end
  end

  ssp_tx u_tx (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .tick_in     (tick),
    .start_in    (tx_start),
    .data_in     (hold_data),
    .len_in      (len),
    .par_en_in   (par_en),
    .par_odd_in  (par_odd),
    .two_stop_in (two_stop),
    .txd_out     (txd_out),
    .busy_out    (tx_busy)
  );

  // ---------------------------------------------------------------------
  // receive side and status
  // ---------------------------------------------------------------------
  logic       rx_done;
  logic [7:0] rx_byte;
  logic       rx_fe;
  logic       rx_pe;
  logic [7:0] rx_data;
  logic       rx_char_ready_flag;
  logic       overrun;
  logic       rx_frame_error_flag;
  logic       par_err;
  logic       overrun_set;

  ssp_rx u_rx (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .tick_in       (tick),
    .rxd_in        (rxd_s),
    .len_in        (len),
    .par_en_in     (par_en),
    .par_odd_in    (par_odd),
    .done_out      (rx_done),
    .data_out      (rx_byte),
    .frame_err_out (rx_fe),
    .par_err_out   (rx_pe)
  );

  assign overrun_set = rx_done && rx_char_ready_flag;

  // a new character beats a read in the same cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_data             <= RX_DATA_RST;
      rx_char_ready_flag  <= 1'b0;
      overrun             <= 1'b0;
      rx_frame_error_flag <= 1'b0;
      par_err             <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_data             <= rx_byte;
        rx_frame_error_flag <= rx_fe;
        par_err             <= rx_pe;
      end
      rx_char_ready_flag <= rx_done || (rx_char_ready_flag && !rd_data);
      overrun <= overrun_set || (overrun && !rd_data);
    end
  end

  // ---------------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------------
  logic [ST_W-1:0] int_stat;
  logic [ST_W-1:0] int_mask;
  logic [ST_W-1:0] int_set;
  logic [ST_W-1:0] status;

  always_comb begin
    status               = '0;
    status[ST_RX_READY]  = rx_char_ready_flag;
    status[ST_OVERRUN]   = overrun;
    status[ST_TX_EMPTY]  = !hold_full;
    status[ST_FRAME_ERR] = rx_frame_error_flag;
    status[ST_PAR_ERR]   = par_err;
    int_set               = '0;
    int_set[ST_RX_READY]  = rx_done;
    int_set[ST_OVERRUN]   = overrun_set;
    int_set[ST_TX_EMPTY]  = tx_start;
    int_set[ST_FRAME_ERR] = rx_done && rx_fe;
    int_set[ST_PAR_ERR]   = rx_done && rx_pe;
  end

  // sticky events clear on read, but a fresh event survives it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      int_stat <= '0;
      int_mask <= INT_MASK_RST;
      irq_out  <= 1'b0;
    end else begin
      int_stat <= int_set | (rd_istat ? '0 : int_stat);
      if (wr_mask) int_mask <= pwdata_in[ST_W-1:0];
      irq_out <= |(int_stat & int_mask);
    end
  end

  // ---------------------------------------------------------------------
  // apb read data and answer
  // ---------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        mapped;

  always_comb begin
    rd_mux = 32'h00000000;
    mapped = 1'b1;
    case (paddr_in)
      OFS_DATA:     rd_mux[7:0] = rx_data;
      OFS_STATUS:   rd_mux[ST_W-1:0] = status;
      OFS_INT_STAT: rd_mux[ST_W-1:0] = int_stat;
      OFS_INT_MASK: rd_mux[ST_W-1:0] = int_mask;
      OFS_CONFIG:   rd_mux[8:0] = {par_odd, par_en, two_stop, len, baud_code};
      default:      mapped = 1'b0;
    endcase
  end

  // answer is formed at setup so every output comes from a flop
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prdata_out  <= 32'h00000000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= apb_setup;
      pslverr_out <= apb_setup && !mapped;
      if (apb_setup) prdata_out <= pwrite_in ? 32'h00000000 : rd_mux;
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_load;
    wr_data && !hold_full;
  endsequence
  sequence s_launch;
    hold_full ##[0:2] tx_busy;
  endsequence

  AST_APB_READY: assert property (apb_setup |=> pready_out ##1 !pready_out)
    else $error("ready not a single access cycle");
  AST_LOAD_SENDS: assert property (s_load |=> s_launch)
    else $error("write did not start transmission");
  AST_RX_READY: assert property (rx_done |=> rx_char_ready_flag)
    else $error("received character not flagged");
  AST_OVERRUN: assert property (rx_done && rx_char_ready_flag |=> overrun)
    else $error("overrun not flagged");
  AST_BAUD_UNDEF: assert property (baud_code >= 4'hE |->
    baud_inc == {7'h00, ssp_baud_x10(4'h0), 4'h0})
    else $error("undefined code not at 110 baud");
  AST_DEFAULT_FMT: assert property (!pin_sync[0] && !pin_sync[1] &&
    !pin_sync[2] |-> len == 2'h3 && !par_en)
    else $error("default format not 8 bits no parity");
  AST_PAR_SENSE: assert property (!par_en |-> !par_odd)
    else $error("parity sense used without parity");
  AST_IRQ: assert property ((int_stat & int_mask) != '0 |=> irq_out)
    else $error("unmasked event without interrupt");
endmodule : ssp_top
`default_nettype wire

//--- ssp_term_model.sv
// Purpose: far-end terminal model on the serial line
// Assumes: fixed bit time; line idles at mark
// Notes:   timed by delays, the far end shares no clock with us
`timescale 1ns/1ps
`default_nettype none
module ssp_term_model #(
  parameter real BIT_NS = 104166.7
) (
  // serial line
  input  wire logic txd_in,
  output logic      rxd_out
);
  // mark while idle so the port never sees a stray start
  initial rxd_out = 1'b1;

  // sample n bits at mid-bit, start bit lands in bit 0
  task automatic catch_bits(input int n, output logic [31:0] b);
    b = '0;
    @(negedge txd_in);
    #(BIT_NS / 2);
    for (int i = 0; i < n; i++) begin
      b[i] = txd_in;
      #(BIT_NS);
    end
  endtask : catch_bits

  // drive a prepared frame bit 0 first, then back to mark
  task automatic send_bits(input logic [31:0] b, input int n);
    #1; // step off the clock edge the caller returned on
    for (int i = 0; i < n; i++) begin
      rxd_out = b[i];
      #(BIT_NS);
    end
    rxd_out = 1'b1;
  endtask : send_bits
endmodule : ssp_term_model
`default_nettype wire

//--- ssp_tb.sv
// Purpose: self-checking bench for the serial port
// Assumes: 9600 baud chosen so frames fit the run
// Notes:   apb reads judged against fixed expectations
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ssp_pkg::*;
  localparam logic [7:0] OFS_NONE = 8'h20; // nothing decoded here
  logic        clk_in, sys_rst_in, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, rxd, txd, irq;
  logic [3:0]  baud;
  logic        stop_sw, odd_sw, len_j1, len_j2, par_j;
  int          miscompares, checks_done;

  ssp_top DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .rxd_in(rxd),
    .txd_out(txd), .stop_bit_count_switch_in(stop_sw),
    .baud_code_bit3_switch_in(baud[3]), .baud_code_bit2_switch_in(baud[2]),
    .baud_code_bit1_switch_in(baud[1]), .baud_code_bit0_switch_in(baud[0]),
    .parity_sense_switch_in(odd_sw), .char_len_jumper1_in(len_j1),
    .char_len_jumper2_in(len_j2), .parity_enable_jumper_in(par_j),
    .irq_out(irq));
  ssp_term_model T (.txd_in(txd), .rxd_out(rxd));

  // 40 ns clock
  always #20 clk_in = ~clk_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  // 7 data bits, odd parity, two stops, start in bit 0
  function automatic logic [10:0] frm(input logic [6:0] d);
    frm = {2'b11, ~^d, d, 1'b0};
  endfunction : frm

  task automatic t_config();
    logic [31:0] r;
    logic        e;
    rd(OFS_CONFIG, 32'h00000070);
    rd(OFS_STATUS, 32'h00000004);
    baud    <= 4'h7;
    odd_sw  <= 1'b1;
    len_j1  <= 1'b1;
    par_j   <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(OFS_CONFIG, 32'h000001E7);
    apb(1'b0, OFS_NONE, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    // one stop, six bits, no parity: sense switch must read as even
    stop_sw <= 1'b1;
    len_j1  <= 1'b0;
    len_j2  <= 1'b1;
    par_j   <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd(OFS_CONFIG, 32'h00000017);
    stop_sw <= 1'b0;
    len_j1  <= 1'b1;
    len_j2  <= 1'b0;
    par_j   <= 1'b1;
    repeat (4) @(posedge clk_in);
    $display("config test done");
  endtask : t_config

  // two characters back to back through the holding stage
  task automatic t_tx();
    logic [31:0] f;
    fork
      T.catch_bits(23, f);
      begin
        wr(OFS_DATA, 32'h35);
        wr(OFS_DATA, 32'h4A);
        rd(OFS_STATUS, 32'h0);
      end
    join
    chk(f, {9'h0, 1'b1, frm(7'h4A), frm(7'h35)});
    chk({31'h0, irq}, 32'h0); // masked event keeps line quiet
    wr(OFS_INT_MASK, 32'h1F);
    repeat (3) @(posedge clk_in);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_INT_STAT, 32'h04);
    repeat (3) @(posedge clk_in);
    chk({31'h0, irq}, 32'h0); // read cleared the sticky bits
    $display("tx test done");
  endtask : t_tx

  // character with a broken stop bit
  task automatic t_rx();
    T.send_bits({22'h0, 1'b0, 1'b1, 7'h5A, 1'b0}, 10);
    repeat (100) @(posedge clk_in);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_STATUS, 32'h0D);
    rd(OFS_INT_STAT, 32'h09);
    rd(OFS_DATA, 32'h5A);
    rd(OFS_STATUS, 32'h0C);
    chk({31'h0, irq}, 32'h0); // nothing left pending
    $display("rx test done");
  endtask : t_rx

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // main sequence; pins start at the factory setting
  initial begin
    clk_in = 1'b0;
    sys_rst_in = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {baud, stop_sw, odd_sw, len_j1, len_j2, par_j} = '0;
    miscompares = 0;
    checks_done = 0;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk({31'h0, txd}, 32'h1);
    t_config();
    t_tx();
    t_rx();
    end_sim();
  end

  // a hang is cut short at 100000 clocks, about a seventh past the expected run
  initial begin
    repeat (100000) @(posedge clk_in);
    miscompares++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
